// [testbench/gas_checker_sva.sv]
// Checker for the global access register block
`timescale 1ns/1ps
module gas_checker (
  // Watched ports
  input wire logic              clk,
  input wire logic              rst,
  input wire gas_pkg::cfg_req_t cfg_req,
  input wire logic              cfg_ready,
  input wire logic [31:0]       cfg_rdata,
  input wire logic              meter_load_np,
  input wire logic [23:0]       meter_load_value,
  input wire gas_pkg::glb_req_t glb_req,
  input wire logic              glb_ack,
  input wire logic [31:0]       glb_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Host request to the data register
  sequence dat_req;
    cfg_req.valid && !cfg_req.smbus && cfg_req.addr == 12'hFFC;
  endsequence
  glb_start_a: assert property (dat_req ##0 !glb_req.valid && !cfg_ready
    |=> glb_req.valid) else $error("no global start");
  glb_hold_a: assert property (glb_req.valid && !glb_ack |=> glb_req.valid)
    else $error("request dropped");
  done_ack_a: assert property (glb_req.valid && glb_ack |=> cfg_ready)
    else $error("no completion");
  read_back_a: assert property (glb_req.valid && glb_ack && !glb_req.write
    |=> cfg_rdata == $past(glb_rdata)) else $error("read data lost");
  lane_pass_a: assert property (glb_req.valid |-> glb_req.byte_en == cfg_req.byte_en
    && glb_req.wdata == cfg_req.wdata) else $error("lanes differ");
  smbus_quiet_a: assert property (cfg_req.smbus |-> !glb_req.valid)
    else $error("smbus went global");
  count_cap_a: assert property (meter_load_np ##1 cfg_ready && cfg_req.addr == 12'h88C
    |-> cfg_rdata == {16'h0000, $past(meter_load_value[23:8])}) else $error("count lost");
  addr_resv_a: assert property (cfg_ready && cfg_req.addr == 12'hFF8
    |-> !cfg_rdata[1:0] && !cfg_rdata[31:19]) else $error("reserved bits set");
endmodule
bind global_space_indirect_access gas_checker gas_checker_inst (.*);

// [testbench/global_space_indirect_access_tb.sv]
// Testbench for the global access register block
`timescale 1ns/1ps
module global_space_indirect_access_tb;
  logic              clk = 1'h0, rst = 1'h1, glb_ack = 1'h0, meter_load_np = 1'h0, cfg_ready;
  logic [23:0]       meter_load_value = 24'h000000;
  logic [31:0]       cfg_rdata, glb_rdata = 32'h00000000;
  logic [31:0]       gmem [0:7] = '{default: 32'h00000000};
  gas_pkg::cfg_req_t cfg_req = '0;
  gas_pkg::glb_req_t glb_req;
  int                bad_count = 0, check_count = 0, lat = 0, wcnt = 0, cyc = 0;
  global_space_indirect_access global_space_indirect_access_inst (.*);
  // Clock
  always #2.5 clk = ~clk;
  // Global space with settable latency, plus the cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    glb_ack <= glb_req.valid && !glb_ack && wcnt == lat;
    if (glb_req.valid && !glb_ack) begin
      wcnt <= (wcnt == lat) ? 0 : wcnt + 1;
      if (wcnt == lat) begin
        chk(32'(glb_req.dword_addr), 32'h00000003);
        glb_rdata <= gmem[glb_req.dword_addr[2:0]];
        for (int i = 0; i < 4; i++)
          if (glb_req.write && glb_req.byte_en[i])
            gmem[glb_req.dword_addr[2:0]][8*i+:8] <= glb_req.wdata[8*i+:8];
      end
    end
    if (cyc == 2000) begin
      bad_count++;
      end_sim();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Access held until ready; reads compare against d
  task automatic acc(input logic w, s, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    cfg_req <= '{1'h1, w, s, a, be, d};
    do
      @(posedge clk);
    while (cfg_ready !== 1'h1);
    if (!w)
      chk(cfg_rdata, d);
    cfg_req <= '0;
    @(posedge clk);
  endtask
  // Verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Register scenarios
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    acc(1'h1, 1'h0, 12'h88C, 4'hF, 32'hFFFFFFFF);
    acc(1'h0, 1'h0, 12'h88C, 4'hF, 32'h00000000);
    acc(1'h0, 1'h0, 12'hFF8, 4'hF, 32'h00000000);
    meter_load_value <= 24'hABCDEF;
    meter_load_np <= 1'h1;
    @(posedge clk);
    meter_load_np <= 1'h0;
    acc(1'h0, 1'h0, 12'h88C, 4'hF, 32'h0000ABCD);
    acc(1'h1, 1'h0, 12'hFF8, 4'hF, 32'hFFFFFFFF);
    acc(1'h0, 1'h0, 12'hFF8, 4'hF, 32'h0007FFFC);
    acc(1'h1, 1'h0, 12'hFF8, 4'hF, 32'h0000000C);
    acc(1'h1, 1'h0, 12'hFFC, 4'hF, 32'h11223344);
    lat = 3;
    acc(1'h1, 1'h0, 12'hFFC, 4'h5, 32'hAABBCCDD);
    acc(1'h0, 1'h0, 12'hFFC, 4'hF, 32'h11BB33DD);
    acc(1'h1, 1'h1, 12'hFFC, 4'hF, 32'hFFFFFFFF);
    acc(1'h0, 1'h1, 12'hFFC, 4'hF, 32'h00000000);
    chk(gmem[3], 32'h11BB33DD);
    acc(1'h0, 1'h0, 12'h100, 4'hF, 32'h00000000);
    end_sim();
  end
endmodule

// [verilog/gas_pkg.sv]
// Package with offsets, field layouts and carrier types for the global access block
package gas_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses within the port's config space)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_METERING_INITIAL_COUNT = 12'h88C;
  localparam logic [11:0] OFF_GLOBAL_ACCESS_ADDRESS  = 12'hFF8;
  localparam logic [11:0] OFF_GLOBAL_ACCESS_DATA     = 12'hFFC;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          COUNT_W          = 16;
  localparam int          METER_W          = 24;
  localparam int          METER_FRAC_DROP  = 8;
  localparam int          GLOBAL_TARGET_ADDRESS_LSB        = 2;
  localparam int          GLOBAL_TARGET_ADDRESS_MSB        = 18;
  localparam int          GLOBAL_TARGET_ADDRESS_W          = GLOBAL_TARGET_ADDRESS_MSB - GLOBAL_TARGET_ADDRESS_LSB + 1;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [16:0] GLOBAL_TARGET_ADDRESS_RESET      = 17'h00000;
  localparam logic [31:0] READ_ZERO        = 32'h00000000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Configuration request from the port's register decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        smbus;
    logic [11:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  // Request toward the switch's global register space
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [16:0] dword_addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } glb_req_t;

  // Access sequencing
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } acc_state_t;

endpackage

// [verilog/global_space_indirect_access.sv]
// Per-port metering count register and global address space indirect access pair
`timescale 1ns/1ps
module global_space_indirect_access #(
  parameter int METER_W = gas_pkg::METER_W,
  parameter int COUNT_W = gas_pkg::COUNT_W
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Configuration access from the port decoder
  input  wire gas_pkg::cfg_req_t     cfg_req,
  output logic                       cfg_ready,
  output logic [31:0]                cfg_rdata,
  // Metering engine load event
  input  wire logic                  meter_load_np,
  input  wire logic [METER_W-1:0]    meter_load_value,
  // Global register space master
  output gas_pkg::glb_req_t          glb_req,
  input  wire logic                  glb_ack,
  input  wire logic [31:0]           glb_rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0]          count_w;
  logic [gas_pkg::GLOBAL_TARGET_ADDRESS_W-1:0] global_target_address_r;
  gas_pkg::acc_state_t         state_r;
  logic [31:0]                 rdata_r;
  logic                        req_write_r;
  logic [3:0]                  req_be_r;
  logic [31:0]                 req_wdata_r;
  logic                        done_nxt;
  logic                        quick_done;
  logic [31:0]                 quick_rdata;
  logic                        take_data;
  logic                        sel_count;
  logic                        sel_addr;
  logic                        sel_data;

  // ----------------------------------------------------------------
  // Metering count capture
  // ----------------------------------------------------------------
  // Metering counter is 24 bits in 0:13:11 format; capture its load
  // Only the load event is seen here; the metering algorithm lives elsewhere
  meter_capture #(
    .METER_W (METER_W),
    .COUNT_W (COUNT_W)
  ) meter_capture_inst (
    .clk        (clk),
    .rst        (rst),
    .load_np    (meter_load_np),
    .load_value (meter_load_value),
    .count      (count_w)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Offset match per register; anything else is unmapped
  always_comb begin
    sel_count = 1'h0;
    sel_addr  = 1'h0;
    sel_data  = 1'h0;
    case (cfg_req.addr)
      gas_pkg::OFF_METERING_INITIAL_COUNT: begin
        sel_count = 1'h1;
      end
      gas_pkg::OFF_GLOBAL_ACCESS_ADDRESS: begin
        sel_addr = 1'h1;
      end
      gas_pkg::OFF_GLOBAL_ACCESS_DATA: begin
        sel_data = 1'h1;
      end
      default: begin
        sel_count = 1'h0; // Unmapped offset
      end
    endcase
  end

  // Host data access taken only when the sequencer is free
  assign take_data = cfg_req.valid && sel_data && !cfg_req.smbus
                     && state_r == gas_pkg::ST_IDLE;

  // ----------------------------------------------------------------
  // Address register
  // ----------------------------------------------------------------
  // Byte-enabled write of the dword address bits; trusted to software
  // Writes wait for idle so the target cannot move under a global access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_target_address_r <= gas_pkg::GLOBAL_TARGET_ADDRESS_RESET;
    end else if (cfg_req.valid && cfg_req.write && sel_addr && state_r == gas_pkg::ST_IDLE) begin
      if (cfg_req.byte_en[0]) begin
        global_target_address_r[5:0] <= cfg_req.wdata[7:2];
      end
      if (cfg_req.byte_en[1]) begin
        global_target_address_r[13:6] <= cfg_req.wdata[15:8];
      end
      if (cfg_req.byte_en[2]) begin
        global_target_address_r[16:14] <= cfg_req.wdata[18:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Indirect data sequencer
  // ----------------------------------------------------------------
  // Idle takes a data access, wait holds it until the global ack
  // DONE gives the answer a cycle of its own after the ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= gas_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        gas_pkg::ST_IDLE: begin
          if (take_data) begin
            state_r <= gas_pkg::ST_WAIT;
          end
        end
        gas_pkg::ST_WAIT: begin
          if (glb_ack) begin
            state_r <= gas_pkg::ST_DONE;
          end
        end
        gas_pkg::ST_DONE: begin
          state_r <= gas_pkg::ST_IDLE;
        end
        default: begin
          state_r <= gas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // Freeze direction, lanes and data when the access is taken, so the
  // global side sees fields from flops for the whole wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_write_r <= '0;
      req_be_r    <= '0;
      req_wdata_r <= gas_pkg::READ_ZERO;
    end else if (take_data) begin
      req_write_r <= cfg_req.write;
      req_be_r    <= cfg_req.byte_en;
      req_wdata_r <= cfg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Global request
  // ----------------------------------------------------------------
  // Request stands for the whole wait; address cannot move meanwhile
  always_comb begin
    glb_req.valid      = state_r == gas_pkg::ST_WAIT;
    glb_req.write      = req_write_r;
    glb_req.dword_addr = global_target_address_r;
    glb_req.byte_en    = req_be_r;
    glb_req.wdata      = req_wdata_r;
  end

  // Latch global read data on its ack; a write answers with zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= gas_pkg::READ_ZERO;
    end else if (state_r == gas_pkg::ST_WAIT && glb_ack) begin
      rdata_r <= req_write_r ? gas_pkg::READ_ZERO : glb_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------
  // Local registers and the SMBus path answer at once, idle only
  always_comb begin
    quick_done  = 1'h0;
    quick_rdata = gas_pkg::READ_ZERO;
    if (cfg_req.valid && state_r == gas_pkg::ST_IDLE) begin
      if (sel_data) begin
        quick_done = cfg_req.smbus;
      end else if (sel_count) begin
        quick_done  = 1'h1;
        quick_rdata = {16'h0000, count_w};
      end else if (sel_addr) begin
        quick_done  = 1'h1;
        quick_rdata = {13'h0000, global_target_address_r, 2'h0};
      end else begin
        quick_done = 1'h1; // Unmapped offsets answer zero
      end
    end
  end

  // Global data accesses answer in DONE, with the latched read word
  always_comb begin
    done_nxt  = quick_done;
    cfg_rdata = quick_rdata;
    if (cfg_req.valid && sel_data && !cfg_req.smbus) begin
      done_nxt  = state_r == gas_pkg::ST_DONE;
      cfg_rdata = done_nxt ? rdata_r : gas_pkg::READ_ZERO;
    end
    cfg_ready = done_nxt;
  end

endmodule

// [verilog/meter_capture.sv]
// Capture of the request metering counter's initial value
`timescale 1ns/1ps
module meter_capture #(
  parameter int METER_W = gas_pkg::METER_W,
  parameter int COUNT_W = gas_pkg::COUNT_W
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Metering counter load event
  input  wire logic               load_np,
  input  wire logic [METER_W-1:0] load_value,
  // Captured count
  output logic      [COUNT_W-1:0] count
);

  // Keep 13 integer plus top 3 fraction bits; low 8 fraction bits are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= gas_pkg::COUNT_RESET;
    end else if (load_np) begin
      count <= load_value[METER_W-1 -: COUNT_W];
    end
  end

endmodule
